// File: core/slcap_pkg.sv
// Package for the slot capability word: offset, field layout and reset value.
package slcap_pkg;
   localparam logic [7:0] SLCAP_WORD_OFFSET = 8'h54;
   localparam logic [31:0] SLCAP_RESET_VALUE = 32'h0000_0000;
   localparam int SLCAP_SLOT_NUM_MSB = 31;
   localparam int SLCAP_SLOT_NUM_LSB = 19;
   localparam int SLCAP_CMD_CPL_NC_BIT = 18;
   localparam int SLCAP_INTERLOCK_BIT = 17;
   localparam int SLCAP_SCALE_MSB = 16;
   localparam int SLCAP_SCALE_LSB = 15;
   localparam int SLCAP_VALUE_MSB = 14;
   localparam int SLCAP_VALUE_LSB = 7;
   localparam int SLCAP_HP_CAPABLE_BIT = 6;
   localparam int SLCAP_HP_SURPRISE_BIT = 5;
   localparam int SLCAP_PWR_IND_BIT = 4;
   localparam int SLCAP_INTERLOCK_CTL_BIT = 11;
   // Scale codes; the ceiling in milliwatts is value times the factor below.
   localparam logic [1:0] SLCAP_SCALE_X1 = 2'h0;
   localparam logic [1:0] SLCAP_SCALE_X0P1 = 2'h1;
   localparam logic [1:0] SLCAP_SCALE_X0P01 = 2'h2;
   localparam logic [1:0] SLCAP_SCALE_X0P001 = 2'h3;
   localparam logic [9:0] SLCAP_MW_X1 = 10'h3E8;
   localparam logic [9:0] SLCAP_MW_X0P1 = 10'h064;
   localparam logic [9:0] SLCAP_MW_X0P01 = 10'h00A;
   localparam logic [9:0] SLCAP_MW_X0P001 = 10'h001;

   typedef struct packed {
      logic [12:0] slot_number;
      logic interlock_present;
      logic [1:0] power_limit_scale;
      logic [7:0] power_limit_value;
      logic hp_capable;
      logic hp_surprise;
      logic power_ind_present;
   } slcap_fields_t;

   typedef struct packed {
      logic valid;
      logic [1:0] power_limit_scale;
      logic [7:0] power_limit_value;
   } slcap_spl_msg_t;
endpackage

// File: core/slcap_spl_tx.sv
// Power-limit message sender: sends once at each link-up rising edge.
`timescale 1ns/1ns
module slcap_spl_tx (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Link state and current fields
   input wire logic link_up_in,
   input wire logic [1:0] scale_in,
   input wire logic [7:0] value_in,
   // Message out, one-cycle valid
   output slcap_pkg::slcap_spl_msg_t msg_out
);
   import slcap_pkg::*;

   logic link_up_reg, link_up_next;
   slcap_spl_msg_t msg_reg, msg_next;

   always_comb begin
      link_up_next = link_up_in;
      msg_next.valid = link_up_in && !link_up_reg;
      // Payload is whatever the fields hold now, programmed or not.
      msg_next.power_limit_scale = scale_in;
      msg_next.power_limit_value = value_in;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         link_up_reg <= 1'b0;
         msg_reg <= '0;
      end else begin
         link_up_reg <= link_up_next;
         msg_reg <= msg_next;
      end
   end

   assign msg_out = msg_reg;

   chk_spl_on_linkup: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(link_up_in) |=> msg_out.valid)
      else $error("message not sent at link up");
   chk_spl_payload: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      msg_out.valid |-> msg_out.power_limit_value == $past(value_in) &&
      msg_out.power_limit_scale == $past(scale_in))
      else $error("message payload differs from fields");
   cov_spl_sent: cover property (@(posedge clk_in) msg_out.valid);
endmodule

// File: core/slcap_top.sv
// Slot capability word with firmware load path, power-limit message and
// surprise-down classification.
`timescale 1ns/1ns
module slcap_top (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Configuration read port
   input wire logic cfg_rd_in,
   input wire logic [7:0] cfg_addr_in,
   output logic [31:0] cfg_rdata_out,
   output logic cfg_rvalid_out,
   // Firmware initialisation write port
   input wire logic fw_wr_in,
   input wire logic [31:0] fw_wdata_in,
   // Slot control and link state
   input wire logic slot_ctl_in,
   input wire logic dl_active_in,
   input wire logic spl_rx_in,
   // Derived outputs
   output logic interlock_drive_out,
   output logic surprise_down_err_out,
   output logic [17:0] power_ceiling_mw_out,
   output slcap_pkg::slcap_spl_msg_t spl_msg_out
);
   import slcap_pkg::*;

   slcap_fields_t fields_reg, fields_next;
   logic [31:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic ilock_reg, ilock_next;
   logic dl_active_reg, dl_active_next;
   logic sde_reg, sde_next;
   logic [17:0] ceiling_reg, ceiling_next;

   // Multiplier in milliwatts so that the ceiling stays an integer.
   function automatic logic [9:0] scale_mw(input logic [1:0] code);
      logic [9:0] f;
      f = SLCAP_MW_X1;
      unique case (code)
         SLCAP_SCALE_X1: f = SLCAP_MW_X1;
         SLCAP_SCALE_X0P1: f = SLCAP_MW_X0P1;
         SLCAP_SCALE_X0P01: f = SLCAP_MW_X0P01;
         SLCAP_SCALE_X0P001: f = SLCAP_MW_X0P001;
      endcase
      return f;
   endfunction

   function automatic logic [31:0] pack_word(input slcap_fields_t f);
      logic [31:0] w;
      w = SLCAP_RESET_VALUE;
      w[SLCAP_SLOT_NUM_MSB:SLCAP_SLOT_NUM_LSB] = f.slot_number;
      w[SLCAP_CMD_CPL_NC_BIT] = 1'b0;
      w[SLCAP_INTERLOCK_BIT] = f.interlock_present;
      w[SLCAP_SCALE_MSB:SLCAP_SCALE_LSB] = f.power_limit_scale;
      w[SLCAP_VALUE_MSB:SLCAP_VALUE_LSB] = f.power_limit_value;
      w[SLCAP_HP_CAPABLE_BIT] = f.hp_capable;
      w[SLCAP_HP_SURPRISE_BIT] = f.hp_surprise;
      w[SLCAP_PWR_IND_BIT] = f.power_ind_present;
      return w;
   endfunction

   always_comb begin
      fields_next = fields_reg;
      // Only the firmware port writes; configuration reads never change it.
      if (fw_wr_in) begin
         fields_next.slot_number =
            fw_wdata_in[SLCAP_SLOT_NUM_MSB:SLCAP_SLOT_NUM_LSB];
         fields_next.interlock_present = fw_wdata_in[SLCAP_INTERLOCK_BIT];
         fields_next.power_limit_scale =
            fw_wdata_in[SLCAP_SCALE_MSB:SLCAP_SCALE_LSB];
         fields_next.power_limit_value =
            fw_wdata_in[SLCAP_VALUE_MSB:SLCAP_VALUE_LSB];
         fields_next.hp_capable = fw_wdata_in[SLCAP_HP_CAPABLE_BIT];
         fields_next.hp_surprise = fw_wdata_in[SLCAP_HP_SURPRISE_BIT];
         fields_next.power_ind_present = fw_wdata_in[SLCAP_PWR_IND_BIT];
      end
   end

   always_comb begin
      rvalid_next = cfg_rd_in;
      rdata_next = 32'h0000_0000;
      // Unmapped offsets read as zero so software sees no stale data.
      if (cfg_rd_in && cfg_addr_in == SLCAP_WORD_OFFSET) begin
         rdata_next = pack_word(fields_reg);
      end
   end

   always_comb begin
      // Lock follows slot control only when an interlock is declared.
      ilock_next = fields_reg.interlock_present && slot_ctl_in;
      ceiling_next = 18'(fields_reg.power_limit_value *
         scale_mw(fields_reg.power_limit_scale));
      dl_active_next = dl_active_in;
      // Received power-limit messages have no path to any error.
      sde_next = dl_active_reg && !dl_active_in &&
         !(fields_reg.hp_capable && fields_reg.hp_surprise);
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         fields_reg <= '0;
         rdata_reg <= SLCAP_RESET_VALUE;
         rvalid_reg <= 1'b0;
         ilock_reg <= 1'b0;
         dl_active_reg <= 1'b0;
         sde_reg <= 1'b0;
         ceiling_reg <= '0;
      end else begin
         fields_reg <= fields_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
         ilock_reg <= ilock_next;
         dl_active_reg <= dl_active_next;
         sde_reg <= sde_next;
         ceiling_reg <= ceiling_next;
      end
   end

   slcap_spl_tx u_spl_tx (
      .clk_in(clk_in),
      .resetn_in(resetn_in),
      .link_up_in(dl_active_in),
      .scale_in(fields_reg.power_limit_scale),
      .value_in(fields_reg.power_limit_value),
      .msg_out(spl_msg_out)
   );

   assign cfg_rdata_out = rdata_reg;
   assign cfg_rvalid_out = rvalid_reg;
   assign interlock_drive_out = ilock_reg;
   assign surprise_down_err_out = sde_reg;
   assign power_ceiling_mw_out = ceiling_reg;

   // Readback: every field as loaded, the fixed bit, and zero when idle.
   chk_slot_num_read: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      cfg_rd_in && cfg_addr_in == SLCAP_WORD_OFFSET |=>
      cfg_rdata_out[31:19] == $past(fields_reg.slot_number))
      else $error("slot number readback wrong");

   chk_cmd_cpl_zero: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !cfg_rdata_out[18])
      else $error("bit 18 not zero");

   chk_rvalid_pulse: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      cfg_rd_in |=> cfg_rvalid_out)
      else $error("read not answered one cycle later");

   chk_rvalid_idle: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !cfg_rd_in |=> !cfg_rvalid_out &&
      cfg_rdata_out == 32'h0000_0000)
      else $error("read answer without a request");

   chk_unmapped_zero: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      cfg_rd_in && cfg_addr_in != SLCAP_WORD_OFFSET |=>
      cfg_rdata_out == 32'h0000_0000)
      else $error("unmapped offset returned data");

   chk_interlock_read: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      cfg_rd_in && cfg_addr_in == SLCAP_WORD_OFFSET |=>
      cfg_rdata_out[17] == $past(fields_reg.interlock_present))
      else $error("interlock bit readback wrong");

   chk_value_read: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      cfg_rd_in && cfg_addr_in == SLCAP_WORD_OFFSET |=>
      cfg_rdata_out[16:7] == {$past(fields_reg.power_limit_scale),
      $past(fields_reg.power_limit_value)})
      else $error("power fields readback wrong");

   chk_hp_bits_read: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      cfg_rd_in && cfg_addr_in == SLCAP_WORD_OFFSET |=>
      cfg_rdata_out[6:4] == {$past(fields_reg.hp_capable),
      $past(fields_reg.hp_surprise),
      $past(fields_reg.power_ind_present)})
      else $error("capability bits readback wrong");

   // The lock output must follow slot control only while declared present.
   chk_interlock_drive: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      interlock_drive_out |-> $past(slot_ctl_in) &&
      $past(fields_reg.interlock_present))
      else $error("interlock driven without cause");

   chk_interlock_follow: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fields_reg.interlock_present && slot_ctl_in |=> interlock_drive_out)
      else $error("interlock not driven");

   chk_no_lock_absent: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !fields_reg.interlock_present |=> !interlock_drive_out)
      else $error("interlock driven while absent");

   // One check per scale code, so a wrong table entry shows at once.
   chk_ceiling_x1: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fields_reg.power_limit_scale == SLCAP_SCALE_X1 |=>
      power_ceiling_mw_out == 18'($past(fields_reg.power_limit_value) *
      10'h3E8))
      else $error("ceiling at unit scale wrong");

   chk_ceiling_x0p1: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fields_reg.power_limit_scale == 2'h1 &&
      $stable(fields_reg) |=> power_ceiling_mw_out ==
      18'($past(fields_reg.power_limit_value) * 10'h064))
      else $error("ceiling at 0.1 scale wrong");

   chk_ceiling_x0p01: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fields_reg.power_limit_scale == SLCAP_SCALE_X0P01 |=>
      power_ceiling_mw_out == 18'($past(fields_reg.power_limit_value) *
      10'h00A))
      else $error("ceiling at 0.01 scale wrong");

   chk_ceiling_x0p001: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fields_reg.power_limit_scale == SLCAP_SCALE_X0P001 |=>
      power_ceiling_mw_out == 18'($past(fields_reg.power_limit_value) *
      10'h001))
      else $error("ceiling at 0.001 scale wrong");

   chk_ceiling_bound: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      power_ceiling_mw_out <= 18'h3E418)
      else $error("ceiling above the largest legal product");

   // The error pulse is judged with the fields seen on the falling edge.
   chk_surprise_down: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $fell(dl_active_reg) |-> surprise_down_err_out ==
      !($past(fields_reg.hp_capable) && $past(fields_reg.hp_surprise)))
      else $error("surprise down classification wrong");

   chk_sde_pulse: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      surprise_down_err_out |=> !surprise_down_err_out)
      else $error("surprise down error longer than one cycle");

   chk_sde_needs_fall: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      surprise_down_err_out |-> $past(dl_active_reg) &&
      !$past(dl_active_in))
      else $error("surprise down error without link loss");

   chk_no_sde_surprise: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      dl_active_reg && !dl_active_in && fields_reg.hp_capable &&
      fields_reg.hp_surprise |=> !surprise_down_err_out)
      else $error("surprise removal flagged as error");

   chk_no_rx_error: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      spl_rx_in && dl_active_in && dl_active_reg |=>
      !surprise_down_err_out)
      else $error("received message raised an error");

   chk_fw_load: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fw_wr_in |=> fields_reg.slot_number ==
      $past(fw_wdata_in[31:19]))
      else $error("firmware load not taken");

   chk_fw_load_power: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fw_wr_in |=> {fields_reg.power_limit_scale,
      fields_reg.power_limit_value} == $past(fw_wdata_in[16:7]))
      else $error("firmware load of power fields not taken");

   chk_fw_load_caps: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      fw_wr_in |=> fields_reg.interlock_present == $past(fw_wdata_in[17])
      && {fields_reg.hp_capable, fields_reg.hp_surprise,
      fields_reg.power_ind_present} == $past(fw_wdata_in[6:4]))
      else $error("firmware load of capability bits not taken");

   chk_fields_hold: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      !fw_wr_in |=> $stable(fields_reg))
      else $error("fields changed without a firmware load");

   // The message leaves once per link-up with whatever the fields hold.
   chk_msg_at_linkup: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      $rose(dl_active_in) |=> spl_msg_out.valid)
      else $error("no power-limit message after link up");

   chk_msg_payload: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      spl_msg_out.valid |-> {spl_msg_out.power_limit_scale,
      spl_msg_out.power_limit_value} ==
      $past({fields_reg.power_limit_scale, fields_reg.power_limit_value}))
      else $error("power-limit message payload wrong");

   chk_msg_single: assert property (
      @(posedge clk_in) disable iff (!resetn_in)
      spl_msg_out.valid |=> !spl_msg_out.valid)
      else $error("power-limit message longer than one cycle");

   cov_fw_then_read: cover property (@(posedge clk_in) fw_wr_in ##1
      cfg_rd_in && cfg_addr_in == SLCAP_WORD_OFFSET);
   cov_sde: cover property (@(posedge clk_in) surprise_down_err_out);
   cov_ilock: cover property (@(posedge clk_in) interlock_drive_out);
   cov_surprise_drop: cover property (@(posedge clk_in) dl_active_reg &&
      !dl_active_in && fields_reg.hp_capable && fields_reg.hp_surprise);
endmodule

// File: test/slcap_link_partner.sv
// Link partner model: raises the link on request and echoes power-limit messages.
`timescale 1ns/1ns
module slcap_link_partner (
   // Clock and reset
   input wire logic clk_in,
   input wire logic resetn_in,
   // Bench control
   input wire logic link_req_in,
   // Link side
   input wire slcap_pkg::slcap_spl_msg_t msg_in,
   output logic dl_active_out,
   output logic spl_rx_out,
   // Last payload seen, for the bench
   output logic [1:0] got_scale_out,
   output logic [7:0] got_value_out,
   output logic [3:0] got_count_out
);
   import slcap_pkg::*;
   assign dl_active_out = link_req_in;
   // Every message is sent straight back, so the port must cope with it.
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         spl_rx_out <= 1'h0;
         got_scale_out <= 2'h0;
         got_value_out <= 8'h00;
         got_count_out <= 4'h0;
      end else begin
         spl_rx_out <= msg_in.valid;
         if (msg_in.valid) begin
            got_scale_out <= msg_in.power_limit_scale;
            got_value_out <= msg_in.power_limit_value;
            got_count_out <= got_count_out + 4'h1;
         end
      end
   end
endmodule

// File: test/test_slot_capabilities_register.sv
// Self-checking bench for the slot capability word and its derived outputs.
`timescale 1ns/1ns
module test_slot_capabilities_register;
   import slcap_pkg::*;
   logic clk_in, resetn_in, cfg_rd_in, fw_wr_in, slot_ctl_in, link_req;
   logic cfg_rvalid_out, interlock_drive_out, surprise_down_err_out;
   logic dl_active_in, spl_rx_in;
   logic [7:0] cfg_addr_in, got_value;
   logic [31:0] fw_wdata_in, cfg_rdata_out, word;
   logic [17:0] power_ceiling_mw_out;
   logic [1:0] got_scale;
   logic [3:0] got_count;
   slcap_spl_msg_t spl_msg_out;
   integer seed;
   int num_errors, checks, i;

   slcap_top uut (.clk_in, .resetn_in, .cfg_rd_in, .cfg_addr_in,
      .cfg_rdata_out, .cfg_rvalid_out, .fw_wr_in, .fw_wdata_in,
      .slot_ctl_in, .dl_active_in, .spl_rx_in, .interlock_drive_out,
      .surprise_down_err_out, .power_ceiling_mw_out, .spl_msg_out);
   slcap_link_partner partner (.clk_in, .resetn_in, .link_req_in(link_req),
      .msg_in(spl_msg_out), .dl_active_out(dl_active_in),
      .spl_rx_out(spl_rx_in), .got_scale_out(got_scale),
      .got_value_out(got_value), .got_count_out(got_count));

   initial begin
      clk_in = 1'h0;
      forever #25 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("Checks %0d, mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Inputs change 5 ns after the edge, well clear of the sampling point.
   task automatic step;
      @(posedge clk_in);
      #5;
   endtask

   // Bit 18 always reads 0 and bits 3:0 are not part of this block.
   function automatic logic [31:0] exp_word(input logic [31:0] d);
      return d & 32'hFFFB_FFF0;
   endfunction

   function automatic logic [17:0] exp_ceil(input logic [31:0] d);
      logic [17:0] mult;
      case (d[16:15])
         2'h0: mult = 18'h003E8;
         2'h1: mult = 18'h00064;
         2'h2: mult = 18'h0000A;
         default: mult = 18'h00001;
      endcase
      return mult * d[14:7];
   endfunction

   task automatic cfg_read(input logic [7:0] addr, input logic [31:0] exp);
      cfg_rd_in = 1'h1;
      cfg_addr_in = addr;
      step;
      cfg_rd_in = 1'h0;
      check("rvalid", cfg_rvalid_out, 1'h1);
      check("rdata", cfg_rdata_out, exp);
      step;
      check("rvalid idle", cfg_rvalid_out, 1'h0);
   endtask

   task automatic run_case(input logic [31:0] d);
      logic ctl;
      logic [3:0] n;
      ctl = 1'($random(seed));
      fw_wr_in = 1'h1;
      // The hot-plug capable bit, with the surprise bit, masks the surprise-down error.
      fw_wdata_in = d;
      step;
      fw_wr_in = 1'h0;
      fw_wdata_in = ~d;
      cfg_read(8'h54, exp_word(d));
      cfg_read(8'h58, 32'h0);
      check("ceiling", power_ceiling_mw_out, exp_ceil(d));
      slot_ctl_in = ctl;
      step;
      check("interlock", interlock_drive_out, d[17] & ctl);
      n = got_count;
      link_req = 1'h1;
      step;
      check("msg", spl_msg_out, {1'h1, d[16:15], d[14:7]});
      step;
      check("msg valid", spl_msg_out.valid, 1'h0);
      step;
      check("msg count", got_count, n + 4'h1);
      check("msg seen", {got_scale, got_value}, d[16:7]);
      check("no error", surprise_down_err_out, 1'h0);
      cfg_read(8'h54, exp_word(d));
      link_req = 1'h0;
      step;
      check("surprise", surprise_down_err_out, !(d[6] & d[5]));
      step;
      check("surprise pulse", surprise_down_err_out, 1'h0);
      $display("Case %h done", d);
   endtask

   initial begin
      num_errors = 0;
      checks = 0;
      seed = 32'hA66D;
      resetn_in = 1'h0;
      cfg_rd_in = 1'h0;
      cfg_addr_in = 8'h00;
      fw_wr_in = 1'h0;
      fw_wdata_in = 32'h0;
      slot_ctl_in = 1'h0;
      link_req = 1'h0;
      repeat (3) @(posedge clk_in);
      #5 resetn_in = 1'h1;
      cfg_read(8'h54, 32'h0);
      link_req = 1'h1;
      step;
      check("early msg", spl_msg_out, {1'h1, 10'h000});
      link_req = 1'h0;
      step;
      check("surprise", surprise_down_err_out, 1'h1);
      $display("Unprogrammed link-up done");
      for (i = 0; i < 12; i++) begin
         word = $random(seed);
         if (i == 0) word = 32'hFFFF_FFFF;
         word[16:15] = i[1:0];
         run_case(word);
      end
      end_sim;
   end

   initial begin
      #100000;
      num_errors++;
      $display("Watchdog expired");
      end_sim;
   end
endmodule
